// ==== design/trxp_pin_logic.v ====
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`include "trxp_map.vh"

module trxp_pin_logic #(
	parameter [7:0] PART_CODE = 8'h5A, // arbitrary value
	parameter [7:0] VERSION = 8'h01, // arbitrary value
	parameter [21:0] VCC_CONV_CYC = `TRXP_VCC_CONV_MS * 1000 * `TRXP_CLK_MHZ,
	parameter [21:0] STRETCH_CYC = `TRXP_STRETCH_US * `TRXP_CLK_MHZ
) (
	input wire i_ref_clk, // 200 MHz clock
	input wire i_rst_n, // synchronous reset, active low
	input wire i_ce, // clock enable, freezes all state
	input wire [7:0] i_addr, // register address
	input wire [7:0] i_wdata, // register write data
	input wire i_wr, // write strobe
	input wire i_rd, // read strobe
	output reg [7:0] o_rdata_ff, // read data, cycle after strobe
	input wire i_supply_ok, // supply above power-on level, async
	input wire i_nv_recalled, // stored settings recalled
	input wire i_loss_input_pin, // loss input pin, async
	input wire i_general_input_one, // general input pin, async
	input wire i_rate_select_input, // rate-select pin, async
	input wire i_txd_pin, // transmit-disable pin, async
	input wire i_transmit_fault_input, // fault input pin, async
	input wire i_loss_qt_high, // high loss quick trip
	input wire i_loss_quick_trip_low, // low loss quick trip
	input wire i_txp_high, // transmit power high quick trip
	input wire i_transmit_power_low_alarm, // transmit power low trip
	input wire [5:0] i_adc_high, // adc high alarm/warning per channel
	input wire [5:0] i_adc_low, // adc low alarm/warning, 0 is supply
	input wire i_temp_conv_done, // temperature conversion done pulse
	output reg o_loss_out_ff, // loss output drive value, always 0
	output reg o_loss_oe_n_ff, // loss output enable, low pulls
	output reg o_rate_select_input_out_ff, // rate output drive value, always 0
	output reg o_rate_select_input_oe_n_ff, // rate output enable, low pulls
	output reg o_txd_out_ff, // transmit-disable output level
	output reg o_txd_oe_n_ff, // transmit-disable enable, low drives
	output reg o_txf_out_ff, // fault output drive value, always 0
	output reg o_txf_oe_n_ff, // fault output enable, low pulls
	output wire o_scl, // serial clock line
	output wire o_cs1, // first chip select
	output wire o_cs2, // second chip select
	output wire o_sda_out, // serial data drive value
	output wire o_sda_oe_n, // serial data enable, low drives
	input wire i_sda_in // serial data line level, async
);
	// synchronisers: stage a feeds stage b only
	reg [6:0] sync_a_ff;
	reg [6:0] sync_b_ff;
	reg rate_select_input_d_ff;
	reg txd_d_ff;
	reg rout_d_ff;
	reg rdy_d_ff;
	wire supply_s = sync_b_ff[0];
	wire loss_s = sync_b_ff[1];
	wire in1_s = sync_b_ff[2];
	wire rate_select_input_s = sync_b_ff[3];
	wire txd_s = sync_b_ff[4];
	wire txf_s = sync_b_ff[5];
	wire sda_s = sync_b_ff[6];

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			sync_a_ff <= 7'h00;
			sync_b_ff <= 7'h00;
		end else if (i_ce) begin
			sync_a_ff <= {i_sda_in, i_transmit_fault_input, i_txd_pin,
				i_rate_select_input, i_general_input_one,
				i_loss_input_pin, i_supply_ok};
			sync_b_ff <= sync_a_ff;
		end
	end

	// software registers
	reg soft_txd_ff;
	reg rate_select_input_soft_ff;
	reg [7:0] cfg_a_ff;
	reg [7:0] latch_b_ff;
	reg [7:0] latch_c_ff;
	reg [7:0] rxctrl_ff;
	reg [7:0] los_hi_ff;
	reg [7:0] loss_quick_trip_low_ff;
	reg [7:0] fault_en_ff;
	reg [7:0] toff_a_ff;
	reg [7:0] toff_b_ff;
	reg [7:0] man_cmd_ff;
	reg [7:0] man_wdata_ff;
	reg [7:0] man_rdata_ff;
	reg man_pend_ff;
	reg man_go;

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			soft_txd_ff <= 1'b0;
			rate_select_input_soft_ff <= 1'b0;
			cfg_a_ff <= `TRXP_CFG_A_RST;
			latch_b_ff <= `TRXP_BYTE_RST;
			latch_c_ff <= `TRXP_BYTE_RST;
			rxctrl_ff <= `TRXP_BYTE_RST;
			los_hi_ff <= `TRXP_BYTE_RST;
			loss_quick_trip_low_ff <= `TRXP_BYTE_RST;
			fault_en_ff <= `TRXP_BYTE_RST;
			toff_a_ff <= `TRXP_BYTE_RST;
			toff_b_ff <= `TRXP_BYTE_RST;
			man_cmd_ff <= `TRXP_BYTE_RST;
			man_wdata_ff <= `TRXP_BYTE_RST;
		end else if (i_ce && i_wr) begin
			if (i_addr == `TRXP_A_STATUS) begin
				soft_txd_ff <= i_wdata[`TRXP_ST_SOFT_TXD];
				rate_select_input_soft_ff <= i_wdata[`TRXP_ST_RATE_SELECT_INPUT_SOFT];
			end else if (i_addr == `TRXP_A_CFG_A) begin
				cfg_a_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_LATCH_B) begin
				latch_b_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_LATCH_C) begin
				latch_c_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_RXCTRL) begin
				rxctrl_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_LOS_HI) begin
				los_hi_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_LOSS_QUICK_TRIP_LOW) begin
				loss_quick_trip_low_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_FAULT_EN) begin
				fault_en_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_TOFF_EN_A) begin
				toff_a_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_TOFF_EN_B) begin
				toff_b_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_MAN_CMD) begin
				man_cmd_ff <= i_wdata;
			end else if (i_addr == `TRXP_A_MAN_WDATA) begin
				man_wdata_ff <= i_wdata;
			end
		end
	end

	// power-on state: ready once supply is up and settings recalled
	wire ready = supply_s & i_nv_recalled;
	reg loss_sel_ff;
	reg [21:0] vcc_cnt_ff;
	reg vcc_conv_ff;
	reg [21:0] stretch_cnt_ff;
	wire disable_any = txd_s | soft_txd_ff;
	wire stretch = disable_any | (stretch_cnt_ff != 22'h000000);

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			loss_sel_ff <= 1'b1;
			vcc_cnt_ff <= 22'h000000;
			vcc_conv_ff <= 1'b0;
			stretch_cnt_ff <= 22'h000000;
		end else if (i_ce) begin
			if (ready) begin
				loss_sel_ff <= cfg_a_ff[`TRXP_CA_LOSS_SEL];
			end
			// first supply conversion timer from power-on
			if (!ready) begin
				vcc_cnt_ff <= 22'h000000;
				vcc_conv_ff <= 1'b0;
			end else if (vcc_cnt_ff == VCC_CONV_CYC - 22'd1) begin
				vcc_conv_ff <= 1'b1;
			end else begin
				vcc_cnt_ff <= vcc_cnt_ff + 22'd1;
			end
			// stretch the disable pulse by the init interval
			if (disable_any) begin
				stretch_cnt_ff <= STRETCH_CYC;
			end else if (stretch_cnt_ff != 22'h000000) begin
				stretch_cnt_ff <= stretch_cnt_ff - 22'd1;
			end
		end
	end

	// loss mux, inversion and rate-select output
	wire loss_mux = loss_sel_ff ? loss_s : i_loss_quick_trip_low;
	wire loss_drv = loss_mux ^ cfg_a_ff[`TRXP_CA_LOSS_INV];
	wire rate_select_input_out = (rate_select_input_s | rate_select_input_soft_ff) ^
		cfg_a_ff[`TRXP_CA_RATE_SELECT_INPUT_INV];

	// fault sources: 5:0 adc, 6/7 loss trips, 8/9 transmit power
	wire [5:0] adc_low_q;
	assign adc_low_q[0] = i_adc_low[0] &
		(vcc_conv_ff | ~cfg_a_ff[`TRXP_CA_VCC_MASK]);
	assign adc_low_q[5] = i_adc_low[5];
	genvar g;
	generate
		for (g = 1; g < 5; g = g + 1) begin : g_mon
			assign adc_low_q[g] = i_adc_low[g] & ~stretch;
		end
	endgenerate
	wire [9:0] src = {i_transmit_power_low_alarm & ~stretch, i_txp_high,
		i_loss_quick_trip_low & ~stretch, i_loss_qt_high,
		i_adc_high | adc_low_q};
	wire [9:0] en = {2'b11, fault_en_ff};
	wire [9:0] lat_en = {latch_c_ff[1:0], latch_b_ff};
	wire txd_fault = cfg_a_ff[`TRXP_CA_TXD_FAULT] & disable_any;
	reg [9:0] latch_ff;

	// latched alarms: set wins, cleared by disable when allowed
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			latch_ff <= 10'h000;
		end else if (i_ce) begin
			latch_ff <= (latch_ff & ~{10{txd_fault}}) |
				(src & en & lat_en);
		end
	end

	wire fault_raw = txf_s | ~ready |
		(|(en & (src | (latch_ff & lat_en))));
	wire tx_fault = fault_raw & ~txd_fault;
	wire turnoff = (|({1'b0, toff_b_ff[0], toff_a_ff} & src)) |
		(toff_b_ff[1] & txf_s);
	reg turnoff_ff;

	// pin outputs, all registered
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_loss_out_ff <= 1'b0;
			o_loss_oe_n_ff <= 1'b1;
			o_rate_select_input_out_ff <= 1'b0;
			o_rate_select_input_oe_n_ff <= 1'b1;
			o_txd_out_ff <= 1'b0;
			o_txd_oe_n_ff <= 1'b1;
			o_txf_out_ff <= 1'b0;
			o_txf_oe_n_ff <= 1'b1;
			turnoff_ff <= 1'b0;
		end else if (i_ce) begin
			o_loss_oe_n_ff <= loss_drv | ~ready;
			o_rate_select_input_oe_n_ff <= rate_select_input_out | ~ready;
			o_txd_out_ff <= tx_fault | disable_any | turnoff;
			o_txd_oe_n_ff <= ~ready;
			o_txf_oe_n_ff <= tx_fault;
			turnoff_ff <= turnoff;
		end
	end

	// slave update scheduler
	reg pend_rx_ff;
	reg pend_los_ff;
	reg start_ff;
	reg [6:0] s_addr_ff;
	reg s_rd_ff;
	reg [7:0] s_wdata_ff;
	reg s_cs2_ff;
	reg man_act_ff;
	wire m_busy;
	wire m_done;
	wire [7:0] m_rdata;
	wire idle = ~m_busy & ~start_ff;
	wire fwd_bit = cfg_a_ff[`TRXP_CA_FWD_PIN] ? rate_select_input_out :
		rxctrl_ff[`TRXP_FWD_BIT];
	wire [7:0] rx_data = {rxctrl_ff[7:2], fwd_bit, rxctrl_ff[0]};
	wire refresh = (ready & ~rdy_d_ff) | (ready & i_temp_conv_done) |
		(ready & disable_any & ~txd_d_ff);

	always @* begin
		man_go = i_wr && (i_addr == `TRXP_A_MAN_CMD);
	end

	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			rate_select_input_d_ff <= 1'b0;
			txd_d_ff <= 1'b0;
			rout_d_ff <= 1'b0;
			rdy_d_ff <= 1'b0;
			pend_rx_ff <= 1'b0;
			pend_los_ff <= 1'b0;
			man_pend_ff <= 1'b0;
			start_ff <= 1'b0;
			s_addr_ff <= 7'h00;
			s_rd_ff <= 1'b0;
			s_wdata_ff <= 8'h00;
			s_cs2_ff <= 1'b0;
			man_act_ff <= 1'b0;
			man_rdata_ff <= 8'h00;
		end else if (i_ce) begin
			rate_select_input_d_ff <= rate_select_input_s;
			txd_d_ff <= disable_any;
			rout_d_ff <= rate_select_input_out;
			rdy_d_ff <= ready;
			start_ff <= 1'b0;
			if (m_done && man_act_ff) begin
				man_rdata_ff <= m_rdata;
				man_act_ff <= 1'b0;
			end
			// issue in order: manual, receiver control, threshold
			if (idle && man_pend_ff) begin
				start_ff <= 1'b1;
				s_addr_ff <= man_cmd_ff[6:0];
				s_rd_ff <= man_cmd_ff[7];
				s_wdata_ff <= man_wdata_ff;
				s_cs2_ff <= 1'b1;
				man_act_ff <= 1'b1;
			end else if (idle && pend_rx_ff) begin
				start_ff <= 1'b1;
				s_addr_ff <= `TRXP_SL_RXCTRL;
				s_rd_ff <= 1'b0;
				s_wdata_ff <= rx_data;
				s_cs2_ff <= 1'b1;
			end else if (idle && pend_los_ff) begin
				start_ff <= 1'b1;
				s_addr_ff <= `TRXP_SL_LOSTHR;
				s_rd_ff <= 1'b0;
				s_wdata_ff <= rate_select_input_s ? los_hi_ff : loss_quick_trip_low_ff;
				s_cs2_ff <= 1'b1;
			end
			// requests set over issue clears
			man_pend_ff <= (man_pend_ff & ~(idle & man_pend_ff)) | man_go;
			pend_rx_ff <= (pend_rx_ff & ~(idle & ~man_pend_ff)) | refresh |
				(ready & (rate_select_input_out ^ rout_d_ff));
			pend_los_ff <= (pend_los_ff &
				~(idle & ~man_pend_ff & ~pend_rx_ff)) | refresh |
				(ready & (rate_select_input_s ^ rate_select_input_d_ff));
		end
	end

	trxp_serial_master u_master (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_start(start_ff),
		.i_addr(s_addr_ff),
		.i_rd(s_rd_ff),
		.i_wdata(s_wdata_ff),
		.i_cs2(s_cs2_ff),
		.i_sda_in(sda_s),
		.o_busy_ff(m_busy),
		.o_done_ff(m_done),
		.o_rdata_ff(m_rdata),
		.o_scl_ff(o_scl),
		.o_cs1_ff(o_cs1),
		.o_cs2_ff(o_cs2),
		.o_sda_out_ff(o_sda_out),
		.o_sda_oe_n_ff(o_sda_oe_n)
	);

	// register read port, data in the cycle after the strobe
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_rdata_ff <= 8'h00;
		end else if (i_ce) begin
			o_rdata_ff <= 8'h00;
			if (i_rd) begin
				if (i_addr == `TRXP_A_STATUS) begin
					o_rdata_ff <= {soft_txd_ff, rate_select_input_soft_ff, in1_s, rate_select_input_s,
						o_txf_oe_n_ff, 1'b0, loss_mux, ~ready};
				end else if (i_addr == `TRXP_A_TURNOFF) begin
					o_rdata_ff <= {7'h00, turnoff_ff};
				end else if (i_addr == `TRXP_A_CFG_A) begin
					o_rdata_ff <= cfg_a_ff;
				end else if (i_addr == `TRXP_A_LATCH_B) begin
					o_rdata_ff <= latch_b_ff;
				end else if (i_addr == `TRXP_A_LATCH_C) begin
					o_rdata_ff <= latch_c_ff;
				end else if (i_addr == `TRXP_A_PART) begin
					o_rdata_ff <= PART_CODE;
				end else if (i_addr == `TRXP_A_VERSION) begin
					o_rdata_ff <= VERSION;
				end else if (i_addr == `TRXP_A_MAN_CMD) begin
					o_rdata_ff <= man_cmd_ff;
				end else if (i_addr == `TRXP_A_MAN_WDATA) begin
					o_rdata_ff <= man_wdata_ff;
				end else if (i_addr == `TRXP_A_MAN_RDATA) begin
					o_rdata_ff <= man_rdata_ff;
				end else if (i_addr == `TRXP_A_MAN_STAT) begin
					o_rdata_ff <= {6'h00, man_pend_ff, m_busy | start_ff};
				end else if (i_addr == `TRXP_A_RXCTRL) begin
					o_rdata_ff <= rxctrl_ff;
				end else if (i_addr == `TRXP_A_LOS_HI) begin
					o_rdata_ff <= los_hi_ff;
				end else if (i_addr == `TRXP_A_LOSS_QUICK_TRIP_LOW) begin
					o_rdata_ff <= loss_quick_trip_low_ff;
				end else if (i_addr == `TRXP_A_FAULT_EN) begin
					o_rdata_ff <= fault_en_ff;
				end else if (i_addr == `TRXP_A_TOFF_EN_A) begin
					o_rdata_ff <= toff_a_ff;
				end else if (i_addr == `TRXP_A_TOFF_EN_B) begin
					o_rdata_ff <= toff_b_ff;
				end
			end
		end
	end
endmodule // trxp_pin_logic

// ==== design/trxp_map.vh ====
`ifndef TRXP_MAP_VH
`define TRXP_MAP_VH

// register offsets (8-bit address space)
`define TRXP_A_STATUS 8'h6E
`define TRXP_A_TURNOFF 8'h71
`define TRXP_A_CFG_A 8'h89
`define TRXP_A_LATCH_B 8'h8A
`define TRXP_A_LATCH_C 8'h8B
`define TRXP_A_PART 8'hCE
`define TRXP_A_VERSION 8'hCF
`define TRXP_A_MAN_CMD 8'hD0
`define TRXP_A_MAN_WDATA 8'hD1
`define TRXP_A_MAN_RDATA 8'hD2
`define TRXP_A_MAN_STAT 8'hD3
`define TRXP_A_RXCTRL 8'hE8
`define TRXP_A_LOS_HI 8'hEB
`define TRXP_A_LOSS_QUICK_TRIP_LOW 8'hF3
`define TRXP_A_FAULT_EN 8'hF8
`define TRXP_A_TOFF_EN_A 8'hFA
`define TRXP_A_TOFF_EN_B 8'hFB

// status register fields
`define TRXP_ST_NOT_READY 0
`define TRXP_ST_RX_LOSS 1
`define TRXP_ST_TX_FAULT 3
`define TRXP_ST_RATE_SELECT_INPUT 4
`define TRXP_ST_IN1 5
`define TRXP_ST_RATE_SELECT_INPUT_SOFT 6
`define TRXP_ST_SOFT_TXD 7

// pin_config_a fields
`define TRXP_CA_LOSS_SEL 0
`define TRXP_CA_LOSS_INV 1
`define TRXP_CA_RATE_SELECT_INPUT_INV 2
`define TRXP_CA_FWD_PIN 3
`define TRXP_CA_TXD_FAULT 4
`define TRXP_CA_VCC_MASK 5

// reset values
`define TRXP_CFG_A_RST 8'h01
`define TRXP_BYTE_RST 8'h00

// slave frame layout and slave register addresses
`define TRXP_SL_RXCTRL 7'h00
`define TRXP_SL_LOSTHR 7'h04
`define TRXP_FWD_BIT 1
`define TRXP_FRAME_BITS 16
`define TRXP_RD_FIRST 8

// timing
`define TRXP_CLK_MHZ 200
`define TRXP_VCC_CONV_MS 13
`define TRXP_STRETCH_US 500
`define TRXP_SCL_HALF 6'd20

`endif

// ==== design/trxp_serial_master.v ====
`timescale 1ns/100ps
`include "trxp_map.vh"

// three-wire master: one 16-bit frame per start pulse, msb first
module trxp_serial_master (
	input wire i_ref_clk, // system clock
	input wire i_rst_n, // synchronous reset, active low
	input wire i_ce, // clock enable
	input wire i_start, // frame request, one cycle
	input wire [6:0] i_addr, // slave register address
	input wire i_rd, // 1 read, 0 write
	input wire [7:0] i_wdata, // write data
	input wire i_cs2, // also select second slave
	input wire i_sda_in, // synchronised data line level
	output reg o_busy_ff, // frame in progress
	output reg o_done_ff, // frame finished, one cycle
	output reg [7:0] o_rdata_ff, // read data
	output reg o_scl_ff, // serial clock line
	output reg o_cs1_ff, // first chip select
	output reg o_cs2_ff, // second chip select
	output reg o_sda_out_ff, // data line drive value
	output reg o_sda_oe_n_ff // data line enable, low drives
);
	localparam S_IDLE = 5'b00001;
	localparam S_LEAD = 5'b00010;
	localparam S_HIGH = 5'b00100;
	localparam S_LOW = 5'b01000;
	localparam S_TAIL = 5'b10000;

	reg [4:0] state_ff;
	reg [5:0] div_ff;
	reg [3:0] bit_ff;
	reg [15:0] shift_ff;
	reg rd_ff;
	wire tick;

	assign tick = (div_ff == `TRXP_SCL_HALF - 6'd1);

	// half-period divider, runs only during a frame
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			div_ff <= 6'h00;
		end else if (i_ce) begin
			if (state_ff == S_IDLE || tick) begin
				div_ff <= 6'h00;
			end else begin
				div_ff <= div_ff + 6'd1;
			end
		end
	end

	// frame sequencer
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state_ff <= S_IDLE;
			bit_ff <= 4'h0;
			shift_ff <= 16'h0000;
			rd_ff <= 1'b0;
			o_busy_ff <= 1'b0;
			o_done_ff <= 1'b0;
			o_rdata_ff <= 8'h00;
			o_scl_ff <= 1'b0;
			o_cs1_ff <= 1'b0;
			o_cs2_ff <= 1'b0;
			o_sda_out_ff <= 1'b0;
			o_sda_oe_n_ff <= 1'b1;
		end else if (i_ce) begin
			o_done_ff <= 1'b0;
			case (state_ff)
			S_IDLE: begin
				o_scl_ff <= 1'b0;
				if (i_start) begin
					// select before any clock edge
					o_cs1_ff <= 1'b1;
					o_cs2_ff <= i_cs2;
					shift_ff <= {i_addr, i_rd, i_wdata};
					o_sda_out_ff <= i_addr[6];
					o_sda_oe_n_ff <= 1'b0;
					rd_ff <= i_rd;
					bit_ff <= 4'h0;
					o_busy_ff <= 1'b1;
					state_ff <= S_LEAD;
				end
			end
			S_LEAD: begin
				if (tick) begin
					o_scl_ff <= 1'b1;
					state_ff <= S_HIGH;
				end
			end
			S_HIGH: begin
				if (tick) begin
					// falling edge: sample read data, shift next bit
					o_scl_ff <= 1'b0;
					if (rd_ff && bit_ff >= `TRXP_RD_FIRST) begin
						o_rdata_ff <= {o_rdata_ff[6:0], i_sda_in};
					end
					if (bit_ff == `TRXP_FRAME_BITS - 1) begin
						state_ff <= S_TAIL;
					end else begin
						bit_ff <= bit_ff + 4'd1;
						shift_ff <= {shift_ff[14:0], 1'b0};
						o_sda_out_ff <= shift_ff[14];
						if (rd_ff && bit_ff == `TRXP_RD_FIRST - 1) begin
							o_sda_oe_n_ff <= 1'b1;
						end
						state_ff <= S_LOW;
					end
				end
			end
			S_LOW: begin
				if (tick) begin
					o_scl_ff <= 1'b1;
					state_ff <= S_HIGH;
				end
			end
			S_TAIL: begin
				if (tick) begin
					o_cs1_ff <= 1'b0;
					o_cs2_ff <= 1'b0;
					o_sda_oe_n_ff <= 1'b1;
					o_busy_ff <= 1'b0;
					o_done_ff <= 1'b1;
					state_ff <= S_IDLE;
				end
			end
			default: begin
				state_ff <= S_IDLE;
			end
			endcase
		end
	end
endmodule // trxp_serial_master

// ==== tb/trxp_props.sv ====
`timescale 1ns/100ps
`include "trxp_map.vh"

// port-level checks on the pin logic and its serial master
module trxp_props #(
	parameter [7:0] PART_CODE = 8'h5A // arbitrary value
) (
	input wire i_ref_clk, // clock
	input wire i_rst_n, // reset, low active
	input wire i_ce, // clock enable
	input wire [7:0] i_addr, // address
	input wire i_rd, // read strobe
	input wire i_supply_ok, // supply good
	input wire [7:0] o_rdata_ff, // read data
	input wire o_txd_oe_n_ff, // disable enable
	input wire o_scl, // serial clock
	input wire o_cs1, // first select
	input wire o_cs2, // second select
	input wire o_sda_oe_n // data enable
);
	reg [4:0] rise_cnt_ff;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// rising clock edges seen in the current frame
	always @(posedge i_ref_clk)
		if (!i_rst_n || !o_cs1)
			rise_cnt_ff <= 5'h00;
		else if ($rose(o_scl))
			rise_cnt_ff <= rise_cnt_ff + 5'h01;
	a_clock_idle_low: assert property (!o_cs1 |-> !o_scl)
		else $error("clock high outside a frame");
	a_second_select: assert property (o_cs2 |-> o_cs1)
		else $error("second select alone");
	a_select_first: assert property ($rose(o_cs1) |-> !o_scl [*8])
		else $error("clock started with select");
	a_clock_half: assert property ($rose(o_scl) |=> o_scl [*7])
		else $error("clock high phase too short");
	a_sixteen_clocks: assert property ($fell(o_cs1) |->
		rise_cnt_ff == 5'h10)
		else $error("frame without sixteen clocks");
	a_data_released: assert property (!o_cs1 |-> o_sda_oe_n)
		else $error("data driven outside a frame");
	a_part_read: assert property (i_ce && i_rd &&
		i_addr == `TRXP_A_PART |=> o_rdata_ff == PART_CODE)
		else $error("part code wrong");
	a_read_idle: assert property (i_ce && !i_rd |=>
		o_rdata_ff == 8'h00)
		else $error("read data outside its cycle");
	a_disable_float: assert property ((i_ce && !i_supply_ok) [*5]
		|=> o_txd_oe_n_ff)
		else $error("disable output driven without supply");
endmodule // trxp_props

bind trxp_pin_logic trxp_props #(.PART_CODE(PART_CODE)) trxp_props_i (.*);

// ==== tb/trxp_slave_model.sv ====
`timescale 1ns/100ps

// far-side slave: samples on rising clock, answers reads
module trxp_slave_model (
	input wire i_scl, // link clock
	input wire i_cs1, // first select
	input wire i_cs2, // second select
	input wire i_mdata, // master data value
	input wire i_moe_n, // master drives when low
	output wire o_line, // resolved data line
	output reg [4:0] o_cnt, // rising edges last frame
	output reg o_cs2_seen // second select in last frame
);
	reg [7:0] mem [0:127];
	reg [15:0] sh;
	reg [7:0] rb;
	reg [4:0] n = 5'h00;
	reg rdm = 1'b0;
	reg en = 1'b0;
	reg drv = 1'b0;
	reg last = 1'b0;
	// an undriven line toggles instead of keeping its level
	assign o_line = !i_moe_n ? i_mdata : (en ? drv : ~last);
	always @(i_scl)
		last = (i_moe_n === 1'b0 || en) ? o_line : ~last;
	// shift master bits; on a read drive data msb first
	always @(posedge i_scl) if (i_cs1 === 1'b1) begin
		n = n + 5'h01;
		if (n == 5'h01)
			o_cs2_seen = i_cs2;
		if (rdm) begin
			en = 1'b1;
			drv = rb[5'h10 - n];
		end else
			sh = {sh[14:0], o_line};
		if (n == 5'h08 && sh[0]) begin
			rdm = 1'b1;
			rb = mem[sh[7:1]];
		end
	end
	// select falling closes the frame and commits a write
	always @(negedge i_cs1) begin
		if (!rdm && n == 5'h10)
			mem[sh[15:9]] = sh[7:0];
		o_cnt = n;
		n = 5'h00;
		rdm = 1'b0;
		en = 1'b0;
	end
endmodule // trxp_slave_model

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`include "trxp_map.vh"

module tb_top;
	localparam [7:0] PART = 8'h5A; // arbitrary value
	logic i_ref_clk = '0, i_rst_n = '0, i_ce = '1, i_wr = '0, i_rd = '0;
	logic i_supply_ok = '0, i_nv_recalled = '0, i_loss_input_pin = '0;
	logic i_general_input_one = '0, i_rate_select_input = '0;
	logic i_txd_pin = '0, i_transmit_fault_input = '0, i_loss_qt_high = '0;
	logic i_loss_quick_trip_low = '0, i_txp_high = '0, i_temp_conv_done = '0;
	logic i_transmit_power_low_alarm = '0, rd_q = '0, m;
	logic [7:0] i_addr = '0, i_wdata = '0, o_rdata_ff, hi, lo, rx, md;
	logic [5:0] i_adc_high = '0, i_adc_low = '0;
	logic o_loss_out_ff, o_loss_oe_n_ff, o_rate_select_input_out_ff, o_rate_select_input_oe_n_ff;
	logic o_txd_out_ff, o_txd_oe_n_ff, o_txf_out_ff, o_txf_oe_n_ff;
	logic o_scl, o_cs1, o_cs2, o_sda_out, o_sda_oe_n;
	logic [15:0] w;
	logic [15:0] exp_q[$];
	wire i_sda_in, cs2_seen;
	wire [4:0] bits;
	int bad_count = 0, checks = 0, n;

	trxp_pin_logic #(.PART_CODE(PART), .VCC_CONV_CYC(22'h32),
		.STRETCH_CYC(22'h14)) trxp_pin_logic_i (.*);
	trxp_slave_model slv (.i_scl(o_scl), .i_cs1(o_cs1), .i_cs2(o_cs2),
		.i_mdata(o_sda_out), .i_moe_n(o_sda_oe_n), .o_line(i_sda_in),
		.o_cnt(bits), .o_cs2_seen(cs2_seen));

	always #2.5 i_ref_clk = ~i_ref_clk;

	task conclude;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task ck(input logic ok, input string s);
		checks++;
		if (!ok) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, s);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e, k);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		exp_q.push_back({k, e});
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
	endtask
	task pause;
		repeat (6) @(posedge i_ref_clk);
	endtask
	// wait for the link to stay quiet
	task idle;
		n = 0;
		for (int i = 0; i < 9000 && n < 60; i++) begin
			@(posedge i_ref_clk);
			n = (o_cs1 === 1'b0) ? n + 1 : 0;
		end
		if (n < 60) begin
			ck(1'b0, "link hang");
			conclude;
		end
	endtask

	// compare each read with the oldest noted value
	always @(posedge i_ref_clk) rd_q <= i_rd && i_ce;
	always @(negedge i_ref_clk) if (rd_q) begin
		if (exp_q.size() == 0)
			ck(1'b0, "unexpected read");
		else begin
			w = exp_q.pop_front();
			ck((o_rdata_ff & w[15:8]) === w[7:0], "read data");
		end
	end

	initial begin
		void'($urandom(6370));
		hi = $urandom;
		lo = $urandom;
		rx = $urandom;
		md = $urandom;
		repeat (4) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		wr(`TRXP_A_PART, 8'hFF);
		rd(`TRXP_A_PART, PART, 8'hFF);
		rd(`TRXP_A_VERSION, 8'h01, 8'hFF);
		rd(`TRXP_A_CFG_A, 8'h01, 8'hFF);
		rd(`TRXP_A_LATCH_B, 8'h00, 8'hFF);
		rd(8'h00, 8'h00, 8'hFF);
		rd(`TRXP_A_STATUS, 8'h01, 8'h01);
		wr(`TRXP_A_LOS_HI, hi);
		wr(`TRXP_A_LOSS_QUICK_TRIP_LOW, lo);
		wr(`TRXP_A_RXCTRL, rx);
		// power-up pushes the slave registers
		i_supply_ok <= 1'b1;
		i_nv_recalled <= 1'b1;
		idle;
		ck(slv.mem[0][1] === rx[1], "rx bit");
		ck(slv.mem[4] === lo, "low level");
		ck(bits === 5'h10 && cs2_seen === 1'b1, "frame");
		// forward the rate output, then invert it
		wr(`TRXP_A_CFG_A, 8'h09);
		i_rate_select_input <= 1'b1;
		i_general_input_one <= 1'b1;
		idle;
		ck(slv.mem[0][1] === 1'b1, "rate bit");
		ck(slv.mem[4] === hi, "high level");
		ck(o_rate_select_input_oe_n_ff === 1'b1, "rate out");
		rd(`TRXP_A_STATUS, 8'h30, 8'h30);
		wr(`TRXP_A_CFG_A, 8'h0D);
		idle;
		ck(slv.mem[0][1] === 1'b0, "inverted bit");
		ck(o_rate_select_input_oe_n_ff === 1'b0, "inverted out");
		// every loss select, invert and source combination
		for (int k = 0; k < 16; k++) begin
			wr(`TRXP_A_CFG_A, {6'h03, k[1], k[0]});
			i_loss_input_pin <= k[2];
			i_loss_quick_trip_low <= k[3];
			pause;
			m = k[0] ? k[2] : k[3];
			ck(o_loss_oe_n_ff === (m ^ k[1]), "loss out");
			rd(`TRXP_A_STATUS, {6'h00, m, 1'b0}, 8'h02);
		end
		// fault input, turnoff and disable sources
		wr(`TRXP_A_TOFF_EN_B, 8'h02);
		i_transmit_fault_input <= 1'b1;
		pause;
		ck(o_txf_oe_n_ff === 1'b1, "fault");
		ck(o_txd_out_ff === 1'b1, "disable");
		rd(`TRXP_A_TURNOFF, 8'h01, 8'h01);
		i_transmit_fault_input <= 1'b0;
		wr(`TRXP_A_STATUS, 8'h80);
		pause;
		ck(o_txf_oe_n_ff === 1'b0, "fault gone");
		ck(o_txd_out_ff === 1'b1, "soft disable");
		wr(`TRXP_A_STATUS, 8'h00);
		pause;
		ck(o_txd_out_ff === 1'b0, "enabled");
		// latched alarm, cleared by disable when enabled
		wr(`TRXP_A_FAULT_EN, 8'h02);
		wr(`TRXP_A_LATCH_B, 8'h02);
		i_adc_high <= 6'h02;
		pause;
		i_adc_high <= 6'h00;
		pause;
		ck(o_txf_oe_n_ff === 1'b1, "latched");
		wr(`TRXP_A_CFG_A, 8'h1D);
		i_txd_pin <= 1'b1;
		pause;
		ck(o_txf_oe_n_ff === 1'b0, "fault held off");
		i_txd_pin <= 1'b0;
		idle;
		ck(o_txf_oe_n_ff === 1'b0, "latch cleared");
		// manual write then read back through the slave
		wr(`TRXP_A_MAN_WDATA, md);
		wr(`TRXP_A_MAN_CMD, 8'h10);
		idle;
		ck(slv.mem[16] === md && cs2_seen === 1'b1, "manual");
		wr(`TRXP_A_MAN_CMD, 8'h90);
		idle;
		rd(`TRXP_A_MAN_STAT, 8'h00, 8'h01);
		rd(`TRXP_A_MAN_RDATA, md, 8'hFF);
		// temperature update rewrites the threshold
		slv.mem[4] = ~hi;
		i_temp_conv_done <= 1'b1;
		@(posedge i_ref_clk);
		i_temp_conv_done <= 1'b0;
		idle;
		ck(slv.mem[4] === hi, "rewrite");
		// supply loss releases the outputs
		i_supply_ok <= 1'b0;
		pause;
		ck(o_txd_oe_n_ff === 1'b1, "float");
		rd(`TRXP_A_STATUS, 8'h01, 8'h01);
		// supply low alarm held off until the first conversion
		wr(`TRXP_A_CFG_A, 8'h2D);
		wr(`TRXP_A_FAULT_EN, 8'h01);
		i_adc_low <= 6'h01;
		i_supply_ok <= 1'b1;
		pause;
		pause;
		ck(o_txf_oe_n_ff === 1'b0, "supply masked");
		repeat (60) @(posedge i_ref_clk);
		ck(o_txf_oe_n_ff === 1'b1, "supply fault");
		// monitor low alarm ignored while disable is stretched
		wr(`TRXP_A_FAULT_EN, 8'h02);
		wr(`TRXP_A_STATUS, 8'h80);
		i_adc_low <= 6'h02;
		pause;
		ck(o_txf_oe_n_ff === 1'b0, "low masked");
		wr(`TRXP_A_STATUS, 8'h00);
		repeat (40) @(posedge i_ref_clk);
		ck(o_txf_oe_n_ff === 1'b1, "low alarm");
		ck(o_loss_out_ff === 1'b0 && o_rate_select_input_out_ff === 1'b0 &&
			o_txf_out_ff === 1'b0, "open drain value");
		pause;
		conclude;
	end
endmodule // tb_top
